// file: rtl/crf_core.sv
// cpu general registers, program counter and condition flags
//
// Overview of operation
// - sixteen byte registers pairing into eight words
// - memory addresses use the whole register pair
// - eighth word register is the stack pointer
// - program counter word wide, lowest bit zero
// - flags read and written by flag instructions
// - branches test negative, zero, overflow, carry
// - bit 7 masks interrupts, set on exception
// - bits 6 and 4 are plain user bits
// - byte arithmetic half carry from bit 3
// - word arithmetic half carry from bit 11
// - bit 3 takes the result sign bit
// - bit 2 set on zero result
// - bit 1 set on arithmetic overflow
// - carry from add, borrow, shifts, bit accumulator
// - reset loads vector word, sets interrupt mask
// - word accesses force address bit zero
// - flags pushed as doubled word, upper restored
// - decimal adjust corrects packed bcd bytes
// - word operands for move, arithmetic; multiply byte by byte, divide word by byte
// - bit operations select bit 0 to 7
`timescale 1ns/1ns
module crf_core (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // execution datapath
    input wire crf_pkg::crf_exec_t exec_in,
    input wire crf_pkg::crf_load_t load_in,
    input wire logic [3:0] rd_sel_in,
    input wire logic [3:0] branch_cond_in,
    input wire logic exc_entry_in,
    input wire logic sp_push_in,
    input wire logic sp_pop_in,
    input wire logic flags_pop_in,
    input wire logic [15:0] flags_pop_word_in,
    input wire logic pc_inc_in,
    input wire logic pc_load_in,
    input wire logic [15:0] pc_value_in,
    input wire logic [2:0] ea_sel_in,
    input wire logic ea_word_in,
    // memory side
    input wire logic mem_rd_valid_in,
    input wire logic [15:0] mem_rd_data_in,
    output logic vec_fetch_out,
    output logic [15:0] fetch_addr_out,
    output logic [15:0] ea_addr_out,
    output logic [15:0] flags_push_word_out,
    // state seen by the datapath
    output logic ready_out,
    output logic [15:0] rd_word_out,
    output logic [7:0] rd_byte_out,
    output logic [15:0] sp_out,
    output logic [15:0] pc_out,
    output logic [7:0] flags_out,
    output logic irq_mask_out,
    output logic branch_taken_out
);

    // ==================================================
    // state
    logic [7:0] regs_r [crf_pkg::NUM_BYTES];
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    crf_pkg::crf_state_t state_r;
    crf_pkg::crf_state_t state_nxt;

    function automatic logic [15:0] pair_value(input logic [2:0] p);
        pair_value = {regs_r[{1'b0, p}], regs_r[{1'b1, p}]};
    endfunction : pair_value

    // ==================================================
    // operand selection
    logic run;
    logic exec_go;
    logic load_go;
    logic [15:0] dst_word;
    logic [15:0] src_word;
    logic [7:0] dst_byte;
    logic [7:0] src_byte;
    logic [15:0] opa;
    logic [15:0] opb;
    logic flag_c;
    logic flag_z;
    logic flag_n;
    logic flag_v;

    assign run = (state_r == crf_pkg::ST_RUN);
    assign exec_go = exec_in.valid && run;
    assign load_go = load_in.valid && run;
    assign dst_word = pair_value(exec_in.dst[2:0]);
    assign src_word = pair_value(exec_in.src[2:0]);
    assign dst_byte = regs_r[exec_in.dst];
    assign src_byte = regs_r[exec_in.src];
    assign opa = exec_in.word ? dst_word : {8'h00, dst_byte};
    assign opb = exec_in.use_imm ? exec_in.imm : (exec_in.word ? src_word : {8'h00, src_byte});
    assign flag_c = flags_r[crf_pkg::FLG_C];
    assign flag_z = flags_r[crf_pkg::FLG_Z];
    assign flag_n = flags_r[crf_pkg::FLG_N];
    assign flag_v = flags_r[crf_pkg::FLG_V];

    // ==================================================
    // adders
    logic is_neg;
    logic is_sub;
    logic add_cin;
    logic [7:0] add_a8;
    logic [7:0] add_b8;
    logic [7:0] sum8;
    logic c8;
    logic h8;
    logic v8;
    logic [15:0] sum16;
    logic c16;
    logic h16;
    logic v16;

    assign is_neg = (exec_in.op == crf_pkg::OP_NEG);
    assign is_sub = (exec_in.op == crf_pkg::OP_SUB) || (exec_in.op == crf_pkg::OP_SUBX)
                 || (exec_in.op == crf_pkg::OP_CMP) || is_neg;
    assign add_cin = ((exec_in.op == crf_pkg::OP_ADDX) || (exec_in.op == crf_pkg::OP_SUBX)) && flag_c;
    assign add_a8 = is_neg ? 8'h00 : opa[7:0];
    assign add_b8 = is_neg ? opa[7:0] : opb[7:0];

    crf_adder #(.WIDTH(8)) u_add8 (
        .a_in(add_a8),
        .b_in(add_b8),
        .cin_in(add_cin),
        .sub_in(is_sub),
        .sum_out(sum8),
        .carry_out(c8),
        .half_out(h8),
        .ovf_out(v8)
    );

    crf_adder #(.WIDTH(16)) u_add16 (
        .a_in(opa),
        .b_in(opb),
        .cin_in(1'b0),
        .sub_in(is_sub),
        .sum_out(sum16),
        .carry_out(c16),
        .half_out(h16),
        .ovf_out(v16)
    );

    // ==================================================
    // multiply, divide, bcd and bit helpers
    logic [15:0] product;
    logic [15:0] quotient;
    logic [15:0] remainder;
    logic div_zero;
    logic [7:0] bit_mask;
    logic bit_val;
    logic bcd_hi;
    logic bcd_lo;

    assign product = {8'h00, opa[7:0]} * {8'h00, opb[7:0]};
    assign div_zero = (opb[7:0] == 8'h00);
    assign quotient = div_zero ? 16'h0000 : dst_word / {8'h00, opb[7:0]};
    assign remainder = div_zero ? 16'h0000 : dst_word % {8'h00, opb[7:0]};
    assign bit_mask = 8'h01 << exec_in.bit_pos;
    assign bit_val = |(opa[7:0] & bit_mask);
    assign bcd_hi = flag_c || (opa[7:0] > crf_pkg::BCD_BYTE_LIMIT);
    assign bcd_lo = flags_r[crf_pkg::FLG_H] || (opa[3:0] > crf_pkg::BCD_DIGIT_LIMIT);

    // ==================================================
    // operation decode
    logic [15:0] res;
    logic [7:0] alu_flags;
    logic res_wr;
    logic res_word;

    always_comb begin
        res = 16'h0000;
        alu_flags = flags_r;
        res_wr = 1'b0;
        res_word = exec_in.word;
        unique case (exec_in.op)
            crf_pkg::OP_NOP: begin
                res_wr = 1'b0;
            end
            crf_pkg::OP_ADD, crf_pkg::OP_ADDX, crf_pkg::OP_SUB, crf_pkg::OP_SUBX,
            crf_pkg::OP_CMP, crf_pkg::OP_NEG: begin
                res_wr = (exec_in.op != crf_pkg::OP_CMP);
                if (exec_in.word) begin
                    res = sum16;
                    alu_flags[crf_pkg::FLG_H] = h16;
                    alu_flags[crf_pkg::FLG_V] = v16;
                    alu_flags[crf_pkg::FLG_C] = c16;
                end else begin
                    res = {8'h00, sum8};
                    alu_flags[crf_pkg::FLG_H] = h8;
                    alu_flags[crf_pkg::FLG_V] = v8;
                    alu_flags[crf_pkg::FLG_C] = c8;
                end
                alu_flags[crf_pkg::FLG_N] = exec_in.word ? res[15] : res[7];
                alu_flags[crf_pkg::FLG_Z] = exec_in.word ? (res == 16'h0000)
                                          : (res[7:0] == 8'h00);
                if ((exec_in.op == crf_pkg::OP_ADDX) || (exec_in.op == crf_pkg::OP_SUBX)) begin
                    alu_flags[crf_pkg::FLG_Z] = flag_z && (res[7:0] == 8'h00);
                end
            end
            crf_pkg::OP_MOVE: begin
                res = opb;
                res_wr = 1'b1;
                alu_flags[crf_pkg::FLG_N] = exec_in.word ? res[15] : res[7];
                alu_flags[crf_pkg::FLG_Z] = exec_in.word ? (res == 16'h0000)
                                          : (res[7:0] == 8'h00);
                alu_flags[crf_pkg::FLG_V] = 1'b0;
            end
            crf_pkg::OP_ADDR_INC, crf_pkg::OP_ADDR_DEC: begin
                res = (exec_in.op == crf_pkg::OP_ADDR_INC) ? dst_word + opb : dst_word - opb;
                res_wr = 1'b1;
                res_word = 1'b1;
            end
            crf_pkg::OP_DEC_ADJ_ADD: begin
                res[7:0] = opa[7:0] + (bcd_hi ? crf_pkg::BCD_HI_ADJ : 8'h00)
                         + (bcd_lo ? crf_pkg::BCD_LO_ADJ : 8'h00);
                res_wr = 1'b1;
                res_word = 1'b0;
                alu_flags[crf_pkg::FLG_C] = bcd_hi;
                alu_flags[crf_pkg::FLG_N] = res[7];
                alu_flags[crf_pkg::FLG_Z] = (res[7:0] == 8'h00);
            end
            crf_pkg::OP_DEC_ADJ_SUB: begin
                res[7:0] = opa[7:0] - (flag_c ? crf_pkg::BCD_HI_ADJ : 8'h00)
                         - (flags_r[crf_pkg::FLG_H] ? crf_pkg::BCD_LO_ADJ : 8'h00);
                res_wr = 1'b1;
                res_word = 1'b0;
                alu_flags[crf_pkg::FLG_N] = res[7];
                alu_flags[crf_pkg::FLG_Z] = (res[7:0] == 8'h00);
            end
            crf_pkg::OP_MUL: begin
                res = product;
                res_wr = 1'b1;
                res_word = 1'b1;
            end
            crf_pkg::OP_DIV: begin
                // a zero divisor leaves the destination untouched
                res = {remainder[7:0], quotient[7:0]};
                res_wr = !div_zero;
                res_word = 1'b1;
                alu_flags[crf_pkg::FLG_N] = opb[7];
                alu_flags[crf_pkg::FLG_Z] = div_zero;
            end
            crf_pkg::OP_SHL, crf_pkg::OP_SHR, crf_pkg::OP_ROTL, crf_pkg::OP_ROTR: begin
                unique case (exec_in.op)
                    crf_pkg::OP_SHL: res[7:0] = {opa[6:0], 1'b0};
                    crf_pkg::OP_SHR: res[7:0] = {1'b0, opa[7:1]};
                    crf_pkg::OP_ROTL: res[7:0] = {opa[6:0], opa[7]};
                    default: res[7:0] = {opa[0], opa[7:1]};
                endcase
                res_wr = 1'b1;
                res_word = 1'b0;
                alu_flags[crf_pkg::FLG_C] = ((exec_in.op == crf_pkg::OP_SHL)
                                          || (exec_in.op == crf_pkg::OP_ROTL))
                                          ? opa[7] : opa[0];
                alu_flags[crf_pkg::FLG_N] = res[7];
                alu_flags[crf_pkg::FLG_Z] = (res[7:0] == 8'h00);
                alu_flags[crf_pkg::FLG_V] = 1'b0;
            end
            crf_pkg::OP_BIT_SET, crf_pkg::OP_BIT_CLR, crf_pkg::OP_BIT_NOT,
            crf_pkg::OP_BIT_STORE: begin
                unique case (exec_in.op)
                    crf_pkg::OP_BIT_SET: res[7:0] = opa[7:0] | bit_mask;
                    crf_pkg::OP_BIT_CLR: res[7:0] = opa[7:0] & ~bit_mask;
                    crf_pkg::OP_BIT_NOT: res[7:0] = opa[7:0] ^ bit_mask;
                    default: res[7:0] = flag_c ? (opa[7:0] | bit_mask)
                                               : (opa[7:0] & ~bit_mask);
                endcase
                res_wr = 1'b1;
                res_word = 1'b0;
            end
            crf_pkg::OP_BIT_TEST: begin
                alu_flags[crf_pkg::FLG_Z] = !bit_val;
            end
            crf_pkg::OP_BIT_LOAD: begin
                alu_flags[crf_pkg::FLG_C] = bit_val;
            end
            crf_pkg::OP_BIT_AND: begin
                alu_flags[crf_pkg::FLG_C] = flag_c & bit_val;
            end
            crf_pkg::OP_BIT_OR: begin
                alu_flags[crf_pkg::FLG_C] = flag_c | bit_val;
            end
            crf_pkg::OP_BIT_XOR: begin
                alu_flags[crf_pkg::FLG_C] = flag_c ^ bit_val;
            end
            crf_pkg::OP_LOAD_FLAGS: begin
                alu_flags = opb[7:0];
            end
            crf_pkg::OP_STORE_FLAGS: begin
                res = {8'h00, flags_r};
                res_wr = 1'b1;
                res_word = 1'b0;
            end
            crf_pkg::OP_FLAGS_AND: begin
                alu_flags = flags_r & opb[7:0];
            end
            crf_pkg::OP_FLAGS_OR: begin
                alu_flags = flags_r | opb[7:0];
            end
            crf_pkg::OP_FLAGS_XOR: begin
                alu_flags = flags_r ^ opb[7:0];
            end
        endcase
    end

    // ==================================================
    // register array writes: stack adjust over load over operation result
    logic sp_adj;
    logic [15:0] sp_nxt;
    logic [15:0] byte_we;
    logic [7:0] byte_wd [crf_pkg::NUM_BYTES];

    assign sp_adj = run && (sp_push_in || sp_pop_in);
    assign sp_nxt = sp_push_in ? sp_out - crf_pkg::SP_STEP : sp_out + crf_pkg::SP_STEP;

    always_comb begin
        for (int i = 0; i < crf_pkg::NUM_BYTES; i++) begin
            byte_we[i] = 1'b0;
            byte_wd[i] = 8'h00;
            if (sp_adj && (i[2:0] == crf_pkg::STACK_PAIR)) begin
                byte_we[i] = 1'b1;
                byte_wd[i] = i[3] ? sp_nxt[7:0] : sp_nxt[15:8];
            end else if (load_go && (load_in.word ? (i[2:0] == load_in.sel[2:0])
                                                  : (i[3:0] == load_in.sel))) begin
                byte_we[i] = 1'b1;
                byte_wd[i] = (!load_in.word || i[3]) ? load_in.data[7:0] : load_in.data[15:8];
            end else if (exec_go && res_wr && (res_word ? (i[2:0] == exec_in.dst[2:0])
                                                        : (i[3:0] == exec_in.dst))) begin
                byte_we[i] = 1'b1;
                byte_wd[i] = (!res_word || i[3]) ? res[7:0] : res[15:8];
            end
        end
    end

    // general registers have no reset value
    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < crf_pkg::NUM_BYTES; i++) begin
            if (byte_we[i]) begin
                regs_r[i] <= byte_wd[i];
            end
        end
    end

    // ==================================================
    // program counter, flags and reset vector fetch
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        if (!run) begin
            if (mem_rd_valid_in) begin
                pc_nxt = mem_rd_data_in & crf_pkg::WORD_ALIGN_MASK;
                state_nxt = crf_pkg::ST_RUN;
            end
        end else if (pc_load_in) begin
            pc_nxt = pc_value_in & crf_pkg::WORD_ALIGN_MASK;
        end else if (pc_inc_in) begin
            pc_nxt = pc_r + crf_pkg::PC_STEP;
        end
    end

    always_comb begin
        flags_nxt = flags_r;
        if (exec_go) begin
            flags_nxt = alu_flags;
        end else if (run && flags_pop_in) begin
            flags_nxt = flags_pop_word_in[15:8];
        end
        if (run && exc_entry_in) begin
            flags_nxt[crf_pkg::FLG_I] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= crf_pkg::ST_VECTOR;
            pc_r <= crf_pkg::RESET_VECTOR_ADDR;
            flags_r <= crf_pkg::FLAGS_RESET;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            flags_r <= flags_nxt;
        end
    end

    // ==================================================
    // branch condition evaluation
    always_comb begin
        unique case (crf_pkg::crf_cond_t'(branch_cond_in))
            crf_pkg::CND_ALWAYS: branch_taken_out = 1'b1;
            crf_pkg::CND_NEVER: branch_taken_out = 1'b0;
            crf_pkg::CND_HIGHER: branch_taken_out = !(flag_c || flag_z);
            crf_pkg::CND_LOWER_SAME: branch_taken_out = flag_c || flag_z;
            crf_pkg::CND_CARRY_CLR: branch_taken_out = !flag_c;
            crf_pkg::CND_CARRY_SET: branch_taken_out = flag_c;
            crf_pkg::CND_NOT_EQUAL: branch_taken_out = !flag_z;
            crf_pkg::CND_EQUAL: branch_taken_out = flag_z;
            crf_pkg::CND_OVF_CLR: branch_taken_out = !flag_v;
            crf_pkg::CND_OVF_SET: branch_taken_out = flag_v;
            crf_pkg::CND_PLUS: branch_taken_out = !flag_n;
            crf_pkg::CND_MINUS: branch_taken_out = flag_n;
            crf_pkg::CND_GREATER_EQ: branch_taken_out = !(flag_n ^ flag_v);
            crf_pkg::CND_LESS: branch_taken_out = flag_n ^ flag_v;
            crf_pkg::CND_GREATER: branch_taken_out = !(flag_z || (flag_n ^ flag_v));
            crf_pkg::CND_LESS_EQ: branch_taken_out = flag_z || (flag_n ^ flag_v);
        endcase
    end

    // ==================================================
    // outputs
    logic [15:0] ea_pair;

    assign ea_pair = pair_value(ea_sel_in);
    assign ea_addr_out = ea_word_in ? (ea_pair & crf_pkg::WORD_ALIGN_MASK) : ea_pair;
    assign fetch_addr_out = run ? (pc_r & crf_pkg::WORD_ALIGN_MASK)
                                : crf_pkg::RESET_VECTOR_ADDR;
    assign vec_fetch_out = !run;
    assign ready_out = run;
    assign flags_push_word_out = {flags_r, flags_r};
    assign rd_word_out = pair_value(rd_sel_in[2:0]);
    assign rd_byte_out = regs_r[rd_sel_in];
    assign sp_out = pair_value(crf_pkg::STACK_PAIR);
    assign pc_out = pc_r;
    assign flags_out = flags_r;
    assign irq_mask_out = flags_r[crf_pkg::FLG_I];

endmodule : crf_core

// file: rtl/crf_pkg.sv
// shared constants and types of the cpu register file and flags block
package crf_pkg;

    // ==================================================
    // sizes and register layout
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int NUM_BYTES = 16;
    localparam logic [2:0] STACK_PAIR = 3'h7;

    // ==================================================
    // condition flag bit positions
    localparam int FLG_I = 7;
    localparam int FLG_UA = 6;
    localparam int FLG_H = 5;
    localparam int FLG_UB = 4;
    localparam int FLG_N = 3;
    localparam int FLG_Z = 2;
    localparam int FLG_V = 1;
    localparam int FLG_C = 0;

    // ==================================================
    // reset values and address constants
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0002;
    localparam logic [15:0] SP_STEP = 16'h0002;
    localparam logic [15:0] WORD_ALIGN_MASK = 16'hFFFE;

    // ==================================================
    // packed bcd correction
    localparam logic [7:0] BCD_HI_ADJ = 8'h60;
    localparam logic [7:0] BCD_LO_ADJ = 8'h06;
    localparam logic [7:0] BCD_BYTE_LIMIT = 8'h99;
    localparam logic [3:0] BCD_DIGIT_LIMIT = 4'h9;

    // ==================================================
    // operations executed on the register file
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDX = 5'h02, OP_SUB = 5'h03,
        OP_SUBX = 5'h04, OP_CMP = 5'h05, OP_NEG = 5'h06, OP_MOVE = 5'h07,
        OP_ADDR_INC = 5'h08, OP_ADDR_DEC = 5'h09, OP_DEC_ADJ_ADD = 5'h0A,
        OP_DEC_ADJ_SUB = 5'h0B, OP_MUL = 5'h0C, OP_DIV = 5'h0D,
        OP_SHL = 5'h0E, OP_SHR = 5'h0F, OP_ROTL = 5'h10, OP_ROTR = 5'h11,
        OP_BIT_SET = 5'h12, OP_BIT_CLR = 5'h13, OP_BIT_NOT = 5'h14,
        OP_BIT_TEST = 5'h15, OP_BIT_LOAD = 5'h16, OP_BIT_STORE = 5'h17,
        OP_BIT_AND = 5'h18, OP_BIT_OR = 5'h19, OP_BIT_XOR = 5'h1A,
        OP_LOAD_FLAGS = 5'h1B, OP_STORE_FLAGS = 5'h1C, OP_FLAGS_AND = 5'h1D,
        OP_FLAGS_OR = 5'h1E, OP_FLAGS_XOR = 5'h1F
    } crf_op_t;

    // branch conditions
    typedef enum logic [3:0] {
        CND_ALWAYS = 4'h0, CND_NEVER = 4'h1, CND_HIGHER = 4'h2, CND_LOWER_SAME = 4'h3,
        CND_CARRY_CLR = 4'h4, CND_CARRY_SET = 4'h5, CND_NOT_EQUAL = 4'h6, CND_EQUAL = 4'h7,
        CND_OVF_CLR = 4'h8, CND_OVF_SET = 4'h9, CND_PLUS = 4'hA, CND_MINUS = 4'hB,
        CND_GREATER_EQ = 4'hC, CND_LESS = 4'hD, CND_GREATER = 4'hE, CND_LESS_EQ = 4'hF
    } crf_cond_t;

    // reset sequence
    typedef enum logic [0:0] {
        ST_VECTOR = 1'b0,
        ST_RUN = 1'b1
    } crf_state_t;

    // one operation from the execution datapath; byte select {low, pair}
    typedef struct packed {
        logic valid;
        crf_op_t op;
        logic word;
        logic [3:0] dst;
        logic [3:0] src;
        logic use_imm;
        logic [15:0] imm;
        logic [2:0] bit_pos;
    } crf_exec_t;

    // register load from the memory side
    typedef struct packed {
        logic valid;
        logic word;
        logic [3:0] sel;
        logic [15:0] data;
    } crf_load_t;

endpackage : crf_pkg

// file: rtl/crf_adder.sv
// add or subtract with carry, half carry and overflow for one width
`timescale 1ns/1ns
module crf_adder #(
    parameter int WIDTH = 8
) (
    // operands
    input wire logic [WIDTH-1:0] a_in,
    input wire logic [WIDTH-1:0] b_in,
    input wire logic cin_in,
    input wire logic sub_in,
    // result
    output logic [WIDTH-1:0] sum_out,
    output logic carry_out,
    output logic half_out,
    output logic ovf_out
);

    logic [WIDTH-1:0] b_x;
    logic c_x;
    logic [WIDTH:0] full;
    logic [WIDTH-4:0] low;

    // subtraction is a + ~b + ~borrow; carry and half carry invert to borrow
    assign b_x = sub_in ? ~b_in : b_in;
    assign c_x = sub_in ? ~cin_in : cin_in;
    assign full = {1'b0, a_in} + {1'b0, b_x} + {{WIDTH{1'b0}}, c_x};
    assign low = {1'b0, a_in[WIDTH-5:0]} + {1'b0, b_x[WIDTH-5:0]} + {{(WIDTH-4){1'b0}}, c_x};
    assign sum_out = full[WIDTH-1:0];
    assign carry_out = full[WIDTH] ^ sub_in;
    assign half_out = low[WIDTH-4] ^ sub_in;
    assign ovf_out = (a_in[WIDTH-1] == b_x[WIDTH-1]) && (sum_out[WIDTH-1] != a_in[WIDTH-1]);

endmodule : crf_adder

// file: bench/crf_core_chk.sv
// port checks of the register file and flags block
`timescale 1ns/1ns
module crf_core_chk (
    input wire logic sys_clk_in, sys_rst_in, mem_rd_valid_in, vec_fetch_out,
    input wire logic ready_out, exc_entry_in, flags_pop_in, pc_inc_in, pc_load_in,
    input wire logic irq_mask_out,
    input wire crf_pkg::crf_exec_t exec_in,
    input wire logic [3:0] rd_sel_in,
    input wire logic [7:0] flags_out,
    input wire logic [15:0] mem_rd_data_in, pc_out, fetch_addr_out, sp_out,
    input wire logic [15:0] flags_push_word_out, flags_pop_word_in, rd_word_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence vec_take;
        vec_fetch_out && mem_rd_valid_in;
    endsequence
    chk_reset_state: assert property ($fell(sys_rst_in) |-> pc_out == 16'h0000
        && flags_out[7] && !ready_out) else $error("reset state wrong");
    chk_vector_load: assert property (vec_take |=> ready_out
        && pc_out == ($past(mem_rd_data_in) & 16'hFFFE)) else $error("vector load wrong");
    chk_fetch_even: assert property (ready_out |-> fetch_addr_out == {pc_out[15:1], 1'h0})
        else $error("fetch address odd");
    chk_push_copy: assert property (flags_push_word_out == {flags_out, flags_out})
        else $error("push word wrong");
    chk_exc_mask: assert property (ready_out && exc_entry_in |=> irq_mask_out)
        else $error("mask not set");
    chk_pop_upper: assert property (ready_out && flags_pop_in && !exec_in.valid
        && !exc_entry_in |=> {8'h00, flags_out} == $past(flags_pop_word_in) >> 8)
        else $error("pop byte wrong");
    chk_stack_pair: assert property (rd_sel_in[2:0] == 3'h7 |-> rd_word_out == sp_out)
        else $error("stack pair wrong");
    chk_pc_step: assert property (ready_out && pc_inc_in && !pc_load_in
        |=> pc_out == $past(pc_out) + 16'h0002) else $error("pc step wrong");
endmodule : crf_core_chk

// file: bench/crf_mem_model.sv
// memory model answering the reset vector fetch
`timescale 1ns/1ns
module crf_mem_model #(
    parameter logic [15:0] VEC = 16'h1235,
    parameter logic [1:0] LAT = 2'h3
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic vec_fetch_out,
    input wire logic [15:0] fetch_addr_out,
    output logic mem_rd_valid_in,
    output logic [15:0] mem_rd_data_in
);
    logic [1:0] wait_r;
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) wait_r <= 2'h0;
        else if (vec_fetch_out && wait_r != LAT) wait_r <= wait_r + 2'h1;
    end
    // only address zero holds the vector; idle data changes only while the fetch waits
    assign mem_rd_valid_in = vec_fetch_out && wait_r == LAT;
    assign mem_rd_data_in = (mem_rd_valid_in && fetch_addr_out == 16'h0000) ? VEC
        : ~VEC ^ {14'h0000, wait_r};
endmodule : crf_mem_model

// file: bench/crf_core_tb_top.sv
// self-checking bench of the register file and flags block
`timescale 1ns/1ns
module crf_core_tb_top;
    logic sys_clk_in = 1'h0, sys_rst_in, mem_rd_valid_in, vec_fetch_out, ready_out;
    logic exc_entry_in = 1'h0, sp_push_in = 1'h0, sp_pop_in = 1'h0, flags_pop_in = 1'h0;
    logic pc_inc_in = 1'h0, pc_load_in = 1'h0, ea_word_in = 1'h1, irq_mask_out, branch_taken_out;
    crf_pkg::crf_exec_t exec_in = '0;
    crf_pkg::crf_load_t load_in = '0;
    logic [3:0] rd_sel_in = 4'h0, branch_cond_in = 4'h0;
    logic [2:0] ea_sel_in = 3'h7;
    logic [7:0] rd_byte_out, flags_out;
    logic [15:0] flags_pop_word_in = 16'h0000, pc_value_in = 16'h0000, mem_rd_data_in;
    logic [15:0] fetch_addr_out, ea_addr_out, flags_push_word_out, rd_word_out, sp_out, pc_out;
    logic [61:0] r;
    int fails = 0, cmp_count = 0, cyc = 0;
    // op, word, start value, immediate, result, flags
    logic [61:0] rows [12] = '{
        {5'h1B, 1'h0, 16'h0000, 16'h0050, 16'h0000, 8'h50},
        {5'h01, 1'h0, 16'h0008, 16'h0008, 16'h0010, 8'h70},
        {5'h01, 1'h0, 16'h00FF, 16'h0001, 16'h0000, 8'h75},
        {5'h01, 1'h0, 16'h007F, 16'h0001, 16'h0080, 8'h7A},
        {5'h03, 1'h1, 16'h1000, 16'h0001, 16'h0FFF, 8'h70},
        {5'h1E, 1'h0, 16'h0000, 16'h0080, 16'h0000, 8'hF0},
        {5'h1F, 1'h0, 16'h0000, 16'h00A5, 16'h0000, 8'h55},
        {5'h0E, 1'h0, 16'h0081, 16'h0000, 16'h0002, 8'h51},
        {5'h07, 1'h1, 16'h1234, 16'h8000, 16'h8000, 8'h59},
        {5'h0A, 1'h0, 16'h000A, 16'h0000, 16'h0070, 8'h51},
        {5'h0C, 1'h1, 16'h0012, 16'h0010, 16'h0120, 8'h51},
        {5'h12, 1'h0, 16'h0000, 16'h0005, 16'h0020, 8'h51}};
    crf_core dut (.*);
    crf_mem_model mem (.*);
    initial forever #20 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (++cyc > 1000) begin
        fails++;
        results();
    end
    task cmp(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task results;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task rst;
        sys_rst_in = 1'h1;
        repeat (16) @(negedge sys_clk_in);
        cmp(pc_out, 16'h0000);
        cmp({8'h00, flags_out}, 16'h0080);
        sys_rst_in = 1'h0;
        for (int k = 0; k < 20 && ready_out !== 1'h1; k++) @(negedge sys_clk_in);
        cmp(pc_out, 16'h1234);
    endtask : rst
    task ld(input logic [3:0] s, input logic [15:0] d);
        load_in = '{1'h1, 1'h1, s, d};
        @(negedge sys_clk_in) load_in = '0;
    endtask : ld
    initial begin
        rst();
        foreach (rows[i]) begin
            r = rows[i];
            ld(4'h0, r[55:40]);
            exec_in = '{1'h1, crf_pkg::crf_op_t'(r[61:57]), r[56], r[56] ? 4'h0 : 4'h8,
                4'h1, 1'h1, r[39:24], r[26:24]};
            @(negedge sys_clk_in) exec_in = '0;
            cmp(rd_word_out, r[23:8]);
            cmp({8'h00, flags_out}, {8'h00, r[7:0]});
        end
        branch_cond_in = 4'h5;
        rd_sel_in = 4'h8;
        flags_pop_word_in = 16'h2BC4;
        flags_pop_in = 1'h1;
        #1 cmp({15'h0000, branch_taken_out}, 16'h0001);
        cmp({8'h00, rd_byte_out}, 16'h0020);
        @(negedge sys_clk_in) flags_pop_in = 1'h0;
        cmp(flags_push_word_out, 16'h2B2B);
        exc_entry_in = 1'h1;
        @(negedge sys_clk_in) exc_entry_in = 1'h0;
        cmp({15'h0000, irq_mask_out}, 16'h0001);
        pc_value_in = 16'h0457;
        pc_load_in = 1'h1;
        @(negedge sys_clk_in) pc_load_in = 1'h0;
        pc_inc_in = 1'h1;
        @(negedge sys_clk_in) pc_inc_in = 1'h0;
        cmp(pc_out, 16'h0458);
        ld(4'h7, 16'h0101);
        rd_sel_in = 4'h7;
        cmp(ea_addr_out, 16'h0100);
        sp_push_in = 1'h1;
        @(negedge sys_clk_in) sp_push_in = 1'h0;
        cmp(sp_out, 16'h00FF);
        sp_pop_in = 1'h1;
        @(negedge sys_clk_in) sp_pop_in = 1'h0;
        cmp(rd_word_out, 16'h0101);
        rst();
        results();
    end
endmodule : crf_core_tb_top
bind crf_core crf_core_chk u_chk (.*);
